// ===== common/fault_pkg.sv
// package for the servo drive fault manager: alarm codes, history depth, structs
// assumes one 25 MHz clock and synchronous active-high reset
package fault_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int CODE_W = 8;
    localparam int HIST_DEPTH = 8;
    localparam int HIST_AW = 3;

    // alarm codes as reported on the fieldbus, packed two hex digits
    localparam logic [7:0] CODE_PARAM = 8'h00;
    localparam logic [7:0] CODE_OVERCURRENT = 8'h10;
    localparam logic [7:0] CODE_OVERVOLT = 8'h40;
    localparam logic [7:0] CODE_OVERSPEED = 8'h51;
    localparam logic [7:0] CODE_OVERLOAD = 8'h70;
    localparam logic [7:0] CODE_HARDWARE = 8'hB0;
    localparam logic [7:0] CODE_ENCODER = 8'hC0;
    localparam logic [7:0] CODE_ABS_ENC = 8'h80;
    localparam logic [7:0] CODE_WARNING = 8'h90;
    localparam logic [7:0] CODE_POS_ERR = 8'hD0;
    localparam logic [7:0] CODE_COMM = 8'hE0;
    localparam logic [7:0] CODE_POWER_LOSS = 8'hF3;
    localparam logic [7:0] CODE_NONE = 8'h99;

    // fault detector inputs, one bit per condition
    typedef struct packed {
        logic param_err;
        logic abs_data_err;
        logic overcurrent;
        logic heatsink_hot;
        logic overvolt;
        logic overspeed;
        logic overload;
        logic hw_err;
        logic phase_err;
        logic overrun;
        logic enc_line_broken;
        logic abs_enc_alarm;
        logic pos_err_overflow;
        logic sync_err;
        logic comm_err;
        logic early_power_on;
    } fault_in_t;

    // host command strobes
    typedef struct packed {
        logic fault_clear_cmd;
        logic servo_disable_cmd;
        logic servo_enable_cmd;
        logic hist_rd;
        logic [HIST_AW-1:0] hist_idx;
    } host_cmd_t;

    typedef struct packed {
        logic power_on;
        logic comm_active;
        logic fault;
    } led_t;

endpackage

// ===== rtl/fault_history_mem.sv
// fault_history_mem: small memory holding past alarm and warning codes
// assumes write strobe and read address synchronous to i_clk
`timescale 1ns/1ps
module fault_history_mem import fault_pkg::*; #(
    parameter int DEPTH = HIST_DEPTH,
    parameter int AW = HIST_AW,
    parameter int W = CODE_W
) (
    // clock
    input wire logic i_clk,
    // write side
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    // read side
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // fault_history_mem

// ===== rtl/servo_drive_fault_manager.sv
// servo_drive_fault_manager: alarm latching, code selection, brake and outputs
// assumes all inputs synchronous to the 25 MHz clock; host link decoded outside
`timescale 1ns/1ps
// How it works
// - brake on alarm, servo-off or power loss
// - any trip disables power stage, alarm state
// - alarm sends details, red lamp, fault output off
// - details on fieldbus and status output
// - parameter or absolute data error gives 00
// - overcurrent or overheating gives 10
// - bus overvoltage gives 40
// - overspeed gives 51
// - overload gives 7x code
// - hardware fault gives B code
// - encoder faults give Cx, absolute gives 8x
// - warning 9x keeps status output on
// - position error overflow gives D0
// - fieldbus errors give E code
// - early power reapply gives F3
// - no alarm reports 99, output on
// - history readable by host
// - clear command leaves alarm state when no fault is present
// - green power and link lamps
// - regen unit opens contact on fault
module servo_drive_fault_manager import fault_pkg::*; #(
    parameter int DEPTH = HIST_DEPTH,
    parameter int AW = HIST_AW
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // fault detectors and power state
    input wire fault_in_t i_faults,
    input wire logic i_warn_cmd_err,
    input wire logic i_power_good,
    input wire logic i_comm_active,
    input wire logic i_regen_contact_closed,
    // host commands
    input wire host_cmd_t i_cmd,
    // drive outputs
    output logic o_power_stage_en,
    output logic o_dyn_brake,
    output logic o_fault_output,
    output logic o_alarm_status_output,
    output logic o_regen_power_cut,
    // host report
    output logic [CODE_W-1:0] o_alarm_code,
    output logic o_alarm_report,
    output logic [CODE_W-1:0] o_hist_code,
    output logic o_hist_valid,
    // panel lamps
    output led_t o_leds
);

    typedef struct packed {
        logic alarm;
        logic warn;
        logic servo_on;
        logic [CODE_W-1:0] code;
        logic report;
        logic [AW-1:0] wptr;
        logic hist_valid;
    } state_t;

    state_t st;
    state_t next_st;
    logic trip;
    logic [CODE_W-1:0] trip_code;
    logic hist_we;
    logic [CODE_W-1:0] hist_rdata;

    // priority encoder from fault inputs to code
    always_comb begin
        trip = 1'b1;
        trip_code = CODE_NONE;
        if (i_faults.hw_err) begin
            trip_code = CODE_HARDWARE;
        end else if (i_faults.overcurrent || i_faults.heatsink_hot) begin
            trip_code = CODE_OVERCURRENT;
        end else if (i_faults.overvolt) begin
            trip_code = CODE_OVERVOLT;
        end else if (i_faults.early_power_on) begin
            trip_code = CODE_POWER_LOSS;
        end else if (i_faults.overspeed) begin
            trip_code = CODE_OVERSPEED;
        end else if (i_faults.overload) begin
            trip_code = CODE_OVERLOAD;
        end else if (i_faults.phase_err || i_faults.overrun || i_faults.enc_line_broken) begin
            trip_code = CODE_ENCODER;
        end else if (i_faults.abs_enc_alarm) begin
            trip_code = CODE_ABS_ENC;
        end else if (i_faults.pos_err_overflow) begin
            trip_code = CODE_POS_ERR;
        end else if (i_faults.sync_err || i_faults.comm_err) begin
            trip_code = CODE_COMM;
        end else if (i_faults.param_err || i_faults.abs_data_err) begin
            trip_code = CODE_PARAM;
        end else begin
            trip = 1'b0;
        end
    end

    always_comb begin
        next_st = st;
        next_st.report = 1'b0;
        next_st.hist_valid = i_cmd.hist_rd;
        hist_we = 1'b0;
        if (i_cmd.servo_disable_cmd) begin
            next_st.servo_on = 1'b0;
        end else if (i_cmd.servo_enable_cmd && !st.alarm) begin
            next_st.servo_on = 1'b1;
        end
        if (i_cmd.fault_clear_cmd && !trip) begin
            next_st.alarm = 1'b0;
            next_st.warn = 1'b0;
            next_st.code = CODE_NONE;
        end
        if (trip && !st.alarm) begin
            // a trip in the clear cycle wins over the clear
            next_st.alarm = 1'b1;
            next_st.warn = 1'b0;
            next_st.servo_on = 1'b0;
            next_st.code = trip_code;
            next_st.report = 1'b1;
            hist_we = 1'b1;
        end else if (i_warn_cmd_err && !st.alarm && !st.warn) begin
            next_st.warn = 1'b1;
            next_st.code = CODE_WARNING;
            next_st.report = 1'b1;
            hist_we = 1'b1;
        end
        if (hist_we) begin
            next_st.wptr = AW'(st.wptr + 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st.alarm <= 1'b0;
            st.warn <= 1'b0;
            st.servo_on <= 1'b0;
            st.code <= CODE_NONE;
            st.report <= 1'b0;
            st.wptr <= '0;
            st.hist_valid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    fault_history_mem #(
        .DEPTH(DEPTH),
        .AW(AW),
        .W(CODE_W)
    ) u_hist (
        .i_clk(i_clk),
        .i_we(hist_we),
        .i_waddr(st.wptr),
        .i_wdata(trip ? trip_code : CODE_WARNING),
        .i_raddr(AW'(st.wptr - 1'b1 - i_cmd.hist_idx)),
        .o_rdata(hist_rdata)
    );

    // power stage, brake and status outputs
    always_comb begin
        o_power_stage_en = st.servo_on && !st.alarm && i_power_good;
        o_dyn_brake = st.alarm || !st.servo_on || !i_power_good;
        o_fault_output = !st.alarm;
        o_alarm_status_output = !st.alarm;
        o_regen_power_cut = !i_regen_contact_closed;
        o_alarm_code = st.code;
        o_alarm_report = st.report;
        o_hist_code = hist_rdata;
        o_hist_valid = st.hist_valid;
        o_leds.power_on = i_power_good;
        o_leds.comm_active = i_comm_active;
        o_leds.fault = st.alarm;
    end

    a_brake_on_alarm: assert property (@(posedge i_clk) disable iff (i_rst)
        st.alarm |-> o_dyn_brake && !o_power_stage_en)
        else $error("brake not engaged during alarm");

    a_trip_latches: assert property (@(posedge i_clk) disable iff (i_rst)
        (trip && !st.alarm) |=> st.alarm && o_alarm_report && st.code == $past(trip_code))
        else $error("trip did not latch alarm");

    a_fault_out_low: assert property (@(posedge i_clk) disable iff (i_rst)
        st.alarm |-> !o_fault_output && o_leds.fault && !o_alarm_status_output)
        else $error("alarm outputs wrong");

    a_overvolt_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults.overvolt && !i_faults.hw_err && !i_faults.overcurrent
        && !i_faults.heatsink_hot) |=> o_alarm_code == CODE_OVERVOLT)
        else $error("overvoltage code wrong");

    a_hw_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults.hw_err) |=> o_alarm_code == CODE_HARDWARE)
        else $error("hardware code wrong");

    a_warn_status_on: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_alarm_code == CODE_WARNING) |-> o_alarm_status_output)
        else $error("warning turned status off");

    a_none_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && !st.warn) |-> o_alarm_code == CODE_NONE && o_alarm_status_output)
        else $error("idle code not 99");

    a_clear_leaves: assert property (@(posedge i_clk) disable iff (i_rst)
        (st.alarm && i_cmd.fault_clear_cmd && !trip) |=> !st.alarm)
        else $error("clear did not leave alarm");

    a_alarm_held: assert property (@(posedge i_clk) disable iff (i_rst)
        (st.alarm && !i_cmd.fault_clear_cmd) |=> st.alarm && $stable(o_alarm_code))
        else $error("alarm dropped without clear");

    a_regen_cut: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_regen_contact_closed |-> o_regen_power_cut)
        else $error("regen contact open but power kept");

    a_param_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{param_err: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_PARAM && !o_alarm_status_output)
        else $error("parameter code wrong");

    a_abs_data_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{abs_data_err: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_PARAM && !o_alarm_status_output)
        else $error("absolute data code wrong");

    a_overcurrent_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{overcurrent: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_OVERCURRENT && !o_alarm_status_output)
        else $error("overcurrent code wrong");

    a_heatsink_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{heatsink_hot: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_OVERCURRENT && !o_alarm_status_output)
        else $error("overheat code wrong");

    a_overspeed_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{overspeed: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_OVERSPEED && !o_alarm_status_output)
        else $error("overspeed code wrong");

    a_overload_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{overload: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_OVERLOAD && !o_alarm_status_output)
        else $error("overload code wrong");

    a_phase_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{phase_err: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_ENCODER && !o_alarm_status_output)
        else $error("phase error code wrong");

    a_overrun_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{overrun: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_ENCODER && !o_alarm_status_output)
        else $error("overrun code wrong");

    a_line_broken_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{enc_line_broken: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_ENCODER && !o_alarm_status_output)
        else $error("broken line code wrong");

    a_abs_enc_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{abs_enc_alarm: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_ABS_ENC && !o_alarm_status_output)
        else $error("absolute encoder code wrong");

    a_pos_err_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{pos_err_overflow: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_POS_ERR && !o_alarm_status_output)
        else $error("position error code wrong");

    a_sync_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{sync_err: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_COMM && !o_alarm_status_output)
        else $error("sync error code wrong");

    a_comm_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{comm_err: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_COMM && !o_alarm_status_output)
        else $error("comm error code wrong");

    a_power_loss_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && i_faults == fault_in_t'{early_power_on: 1'b1, default: 1'b0})
        |=> o_alarm_code == CODE_POWER_LOSS && !o_alarm_status_output)
        else $error("power loss code wrong");

    a_warn_latch: assert property (@(posedge i_clk) disable iff (i_rst)
        (!st.alarm && !st.warn && !trip && i_warn_cmd_err)
        |=> o_alarm_code == CODE_WARNING && o_alarm_report && o_alarm_status_output)
        else $error("warning not reported");

    a_clear_warn: assert property (@(posedge i_clk) disable iff (i_rst)
        (st.warn && !st.alarm && i_cmd.fault_clear_cmd && !trip)
        |=> !st.warn && o_alarm_code == CODE_NONE)
        else $error("clear did not drop warning");

    a_trip_wins: assert property (@(posedge i_clk) disable iff (i_rst)
        (st.alarm && trip)
        |=> st.alarm)
        else $error("alarm cleared while fault present");

    a_report_code: assert property (@(posedge i_clk) disable iff (i_rst)
        o_alarm_report
        |-> o_alarm_code != CODE_NONE)
        else $error("report without code");

    a_lamps_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        o_leds.power_on == i_power_good
        && o_leds.comm_active == i_comm_active)
        else $error("green lamps wrong");

    a_power_loss_brake: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_power_good
        |-> o_dyn_brake && !o_power_stage_en)
        else $error("brake off without power");

    a_servo_off_brake: assert property (@(posedge i_clk) disable iff (i_rst)
        i_cmd.servo_disable_cmd
        |=> o_dyn_brake)
        else $error("brake off after servo off");

    a_no_enable_alarm: assert property (@(posedge i_clk) disable iff (i_rst)
        st.alarm
        |=> !st.servo_on)
        else $error("servo enabled during alarm");

    a_hist_read: assert property (@(posedge i_clk) disable iff (i_rst)
        i_cmd.hist_rd
        |=> o_hist_valid)
        else $error("history read not answered");

    a_trip_history: assert property (@(posedge i_clk) disable iff (i_rst)
        (trip && !st.alarm)
        |=> st.wptr == AW'($past(st.wptr) + 1'b1))
        else $error("trip not written to history");

endmodule // servo_drive_fault_manager

// ===== verification/host_model.sv
// host_model: host controller side of the command link, one-cycle command strobes
// assumes bench requests are synchronous to i_clk and last one cycle
`timescale 1ns/1ps
module host_model import fault_pkg::*; (
    // clock
    input wire logic i_clk,
    // bench request and drive report
    input wire host_cmd_t i_req,
    input wire logic i_alarm_report,
    input wire logic [CODE_W-1:0] i_alarm_code,
    // commands to the drive, setup restart flag
    output host_cmd_t o_cmd,
    output logic o_restart
);
    initial o_cmd = '0;
    initial o_restart = 1'b0;
    always @(posedge i_clk) begin
        o_cmd <= i_req;
        o_restart <= i_alarm_report && (i_alarm_code == CODE_PARAM);
    end
endmodule // host_model

// ===== verification/servo_drive_fault_manager_bench.sv
// servo_drive_fault_manager_bench: trips every detector, warnings, clear, history, brake
// assumes host_model in front of the command port and a 25 MHz clock
`timescale 1ns/1ps
module servo_drive_fault_manager_bench import fault_pkg::*; ;
    localparam logic [7:0] TAB [16] = '{8'hF3, 8'hE0, 8'hE0, 8'hD0, 8'h80, 8'hC0, 8'hC0,
        8'hC0, 8'hB0, 8'h70, 8'h51, 8'h40, 8'h10, 8'h10, 8'h00, 8'h00};
    logic i_clk = 0, i_rst = 1, warn = 0, pg = 1, ca = 1, regen = 1;
    logic pwr_en, brake, fout, stat, cut, rep, hv, restart;
    logic [7:0] code, hcode;
    fault_in_t faults = '0;
    host_cmd_t req = '0, cmd;
    led_t leds;
    logic [7:0] exp_q[$], hist_q[$];
    int n_mismatch = 0, samples_checked = 0, n_restart = 0;
    initial forever #20 i_clk = ~i_clk;
    host_model u_host_model (.i_clk(i_clk), .i_req(req), .i_alarm_report(rep),
        .i_alarm_code(code), .o_cmd(cmd), .o_restart(restart));
    servo_drive_fault_manager u_servo_drive_fault_manager (.i_clk(i_clk), .i_rst(i_rst),
        .i_faults(faults), .i_warn_cmd_err(warn), .i_power_good(pg), .i_comm_active(ca),
        .i_regen_contact_closed(regen), .i_cmd(cmd), .o_power_stage_en(pwr_en),
        .o_dyn_brake(brake), .o_fault_output(fout), .o_alarm_status_output(stat),
        .o_regen_power_cut(cut), .o_alarm_code(code), .o_alarm_report(rep),
        .o_hist_code(hcode), .o_hist_valid(hv), .o_leds(leds));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic host(input host_cmd_t c);
        req <= c;
        tick(1);
        req <= '0;
        tick(3);
    endtask
    task automatic results();
        $display("mismatches %0d checked %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // result watcher: oldest note against each report or history word
    always @(posedge i_clk) begin
        if (restart === 1'b1) n_restart++;
    end
    always @(negedge i_clk) begin
        if (rep === 1'b1) check(code, exp_q.size() ? exp_q.pop_front() : 8'hEE);
        if (hv === 1'b1) check(hcode, hist_q.size() ? hist_q.pop_front() : 8'hEE);
    end
    initial begin
        tick(5000);
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(32'h16f8));
        tick(10);
        i_rst <= 0;
        tick(2);
        check(code, 8'h99);
        check({stat, fout, brake}, 3'b111);
        for (int i = 0; i < 16; i++) begin
            host('{servo_enable_cmd: 1, default: 0});
            check({pwr_en, brake}, 2'b10);
            faults <= fault_in_t'(16'h8000 >> i);
            exp_q.push_back(TAB[15-i]);
            tick(2);
            check({fout, stat, brake, pwr_en, leds.fault}, 5'b00101);
            faults <= fault_in_t'(16'($urandom));
            tick(2);
            faults <= '0;
            host('{servo_enable_cmd: 1, default: 0});
            check({code, pwr_en}, {TAB[15-i], 1'b0});
            hist_q.push_back(TAB[15-i]);
            host('{hist_rd: 1, default: 0});
            host('{fault_clear_cmd: 1, default: 0});
            check({code, fout, stat, leds.fault}, {8'h99, 3'b110});
        end
        warn <= 1;
        exp_q.push_back(8'h90);
        tick(2);
        check({code, stat, fout}, {8'h90, 2'b11});
        warn <= 0;
        host('{fault_clear_cmd: 1, default: 0});
        check(code, 8'h99);
        host('{servo_enable_cmd: 1, default: 0});
        host('{servo_disable_cmd: 1, default: 0});
        check(brake, 1'b1);
        check({leds.power_on, leds.comm_active}, 2'b11);
        faults.overvolt <= 1;
        exp_q.push_back(8'h40);
        tick(3);
        faults <= '0;
        i_rst <= 1;
        tick(1);
        i_rst <= 0;
        tick(1);
        check({code, fout}, {8'h99, 1'b1});
        regen <= 0;
        ca <= 0;
        tick(1);
        check({cut, leds.comm_active}, 2'b10);
        if (cut === 1'b1) pg <= 0;
        tick(2);
        check({brake, leds.power_on}, 2'b10);
        check(8'(exp_q.size() + hist_q.size()), 8'h00);
        check(8'(n_restart), 8'h02);
        results();
    end
endmodule // servo_drive_fault_manager_bench
